//--- bus_trigger_regs.vh
// Contract
// - Normalize erases every trigger truth table and loads the placement delay count.
// - After the trigger, record the delay cycles, then freeze the trace buffer.
// - Normalize delay counts: bottom 4, middle 85, top 165, decimal.
// - Advance-window rerun restarts target, same spec, delay count plus 170.
// - Match a 48-channel bus in byte fields; can trigger outside a value or range.
// - Inversion request is a one-shot flag for the next field term only.
// - Inverted plain term: fill table with ones, then zeros at specified entries.
// - Plain term: clear table to zeros, then ones at specified entries.
// - Inverted OR term keeps table contents and writes only the inverted entries.
// - Filtered capture discards the trigger spec and stores only matching cycles.
// - Filtered capture runs until the buffer is full and reports free entries.
// - Live snapshot clears the restart flag, arms its own trigger, captures 170 cycles.
`ifndef BUS_TRIGGER_REGS_VH
`define BUS_TRIGGER_REGS_VH
`define ADDR_CTRL 8'h00
`define ADDR_TERM 8'h04
`define ADDR_DELAY 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_IRQ_STAT 8'h10
`define ADDR_IRQ_MASK 8'h14
`define ADDR_QUAL 8'h18
`define ADDR_CONFIG 8'h1C
`define ADDR_TRACE_IDX 8'h20
`define ADDR_TRACE_LO 8'h24
`define ADDR_TRACE_HI 8'h28
`define CTRL_NORM_BOTTOM 0
`define CTRL_NORM_MIDDLE 1
`define CTRL_NORM_TOP 2
`define CTRL_ADVANCE 3
`define CTRL_FILTER 4
`define CTRL_SNAPSHOT 5
`define CTRL_START 6
`define CTRL_INVERT 7
`define CTRL_ALSO 8
`define TERM_SEL_LSB 0
`define TERM_LO_LSB 8
`define TERM_HI_LSB 16
`define QUAL_EN 0
`define QUAL_SEL_LSB 1
`define QUAL_VAL_LSB 8
`define CONFIG_RESTART 0
`define IRQ_TRIG 0
`define IRQ_FROZEN 1
`define DELAY_BOTTOM 16'h0004
`define DELAY_MIDDLE 16'h0055
`define DELAY_TOP 16'h00A5
`define WINDOW_STEP 16'h00AA
`define DELAY_RESET 16'h0004
`endif

//--- bus_trigger_trace_capture.v
`timescale 1ns/1ps
`default_nettype none
`include "bus_trigger_regs.vh"
module bus_trigger_trace_capture #(
    parameter FIELDS = 6,
    parameter DEPTH = 170,
    parameter PTR_W = 8
) (
    input wire core_clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [31:0] rdata,
    output wire irq,
    input wire [8*FIELDS-1:0] target_bus,
    input wire target_cycle_strobe,
    output reg target_restart
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SEARCH = 3'h1;
    localparam ST_DELAY = 3'h2;
    localparam ST_FROZEN = 3'h3;
    localparam ST_FILTER = 3'h4;
    localparam [PTR_W-1:0] LAST = DEPTH - 1;
    localparam [PTR_W-1:0] DEPTH_W = DEPTH;

    // Ones at the term's range, zeros if inverted; the rest cleared, filled, or kept for an OR term.
    function [255:0] fill_table;
        input [255:0] old;
        input [7:0] lo;
        input [7:0] hi;
        input inv;
        input also;
        integer i;
        begin
            for (i = 0; i < 256; i = i + 1)
            begin
                if (i >= lo && i <= hi)
                    fill_table[i] = ~inv;
                else
                    fill_table[i] = also ? old[i] : inv;
            end
        end
    endfunction

    reg [8*FIELDS-1:0] bus_s1;
    reg [8*FIELDS-1:0] bus_s2;
    reg strobe_s1;
    reg strobe_s2;
    reg strobe_s3;
    reg [2:0] state;
    reg [15:0] delay;
    reg [15:0] delay_left;
    reg filter_mode;
    reg inv_flag;
    reg also_flag;
    reg restart_flag;
    wire [FIELDS-1:0] field_en;
    reg qual_en;
    reg [2:0] qual_sel;
    reg [7:0] qual_val;
    reg qual_seen;
    reg [PTR_W-1:0] wr_ptr;
    reg [PTR_W-1:0] count;
    reg [PTR_W-1:0] trace_idx;
    reg [1:0] irq_stat;
    reg [1:0] irq_mask;
    reg [1:0] events;
    reg [8*FIELDS-1:0] trace_mem [0:DEPTH-1];
    wire [FIELDS-1:0] lookup;
    wire cyc = strobe_s2 & ~strobe_s3;
    wire ctrl_wr = wr_en && addr == `ADDR_CTRL;
    wire term_wr = wr_en && addr == `ADDR_TERM;
    wire [2:0] term_sel = wdata[`TERM_SEL_LSB+2:`TERM_SEL_LSB];
    wire [7:0] term_lo = wdata[`TERM_LO_LSB+7:`TERM_LO_LSB];
    wire [7:0] term_hi = wdata[`TERM_HI_LSB+7:`TERM_HI_LSB];
    wire cmd_norm = ctrl_wr && (wdata[`CTRL_NORM_BOTTOM] || wdata[`CTRL_NORM_MIDDLE]
        || wdata[`CTRL_NORM_TOP]);
    wire cmd_filter = ctrl_wr && wdata[`CTRL_FILTER];
    wire cmd_advance = ctrl_wr && wdata[`CTRL_ADVANCE];
    wire cmd_snap = ctrl_wr && wdata[`CTRL_SNAPSHOT];
    wire cmd_start = ctrl_wr && wdata[`CTRL_START];
    wire clear_spec = cmd_norm || cmd_filter || cmd_snap;
    wire go = cmd_advance || cmd_snap || cmd_start;
    wire go_filter = (cmd_filter || filter_mode) && !cmd_norm && !cmd_snap;
    wire match = &(~field_en | lookup);
    wire [7:0] qual_byte = bus_s2[8*qual_sel+:8];
    wire qual_hit = qual_byte == qual_val;
    wire [PTR_W-1:0] next_ptr = (wr_ptr == LAST) ? {PTR_W{1'b0}} : wr_ptr + 1'b1;
    wire [PTR_W-1:0] free_entries = DEPTH_W - count;
    wire store_search = cyc && (state == ST_SEARCH || state == ST_DELAY);
    wire store_filter = cyc && state == ST_FILTER && match && (qual_seen || !qual_en || qual_hit);
    wire store = store_search || store_filter;

    // Pins are asynchronous to core_clk; a cycle is the rising strobe edge.
    always @(posedge core_clk)
    begin
        bus_s1 <= target_bus;
        bus_s2 <= bus_s1;
        if (rst)
        begin
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
            strobe_s3 <= 1'b0;
        end
        else
        begin
            strobe_s1 <= target_cycle_strobe;
            strobe_s2 <= strobe_s1;
            strobe_s3 <= strobe_s2;
        end
    end

    genvar g;
    generate
        for (g = 0; g < FIELDS; g = g + 1)
        begin : field
            reg [255:0] table_bits;
            reg enabled;
            assign lookup[g] = table_bits[bus_s2[8*g+7:8*g]];
            assign field_en[g] = enabled;
            always @(posedge core_clk)
            begin
                if (rst || clear_spec)
                begin
                    table_bits <= 256'h0;
                    enabled <= 1'b0;
                end
                else if (term_wr && term_sel == g)
                begin
                    table_bits <= fill_table(table_bits, term_lo, term_hi, inv_flag, also_flag);
                    enabled <= 1'b1;
                end
            end
        end
    endgenerate

    always @(posedge core_clk)
    begin
        if (store)
            trace_mem[wr_ptr] <= bus_s2;
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            delay <= `DELAY_RESET;
            delay_left <= 16'h0000;
            filter_mode <= 1'b0;
            inv_flag <= 1'b0;
            also_flag <= 1'b0;
            restart_flag <= 1'b0;
            qual_en <= 1'b0;
            qual_sel <= 3'h0;
            qual_val <= 8'h00;
            qual_seen <= 1'b0;
            wr_ptr <= {PTR_W{1'b0}};
            count <= {PTR_W{1'b0}};
            trace_idx <= {PTR_W{1'b0}};
            target_restart <= 1'b0;
            events <= 2'b00;
        end
        else
        begin
            target_restart <= 1'b0;
            events <= 2'b00;
            if (term_wr)
            begin
                inv_flag <= 1'b0;
                also_flag <= 1'b0;
            end
            if (ctrl_wr)
            begin
                if (wdata[`CTRL_INVERT])
                    inv_flag <= 1'b1;
                if (wdata[`CTRL_ALSO])
                    also_flag <= 1'b1;
            end
            if (cmd_norm)
            begin
                filter_mode <= 1'b0;
                if (wdata[`CTRL_NORM_BOTTOM])
                    delay <= `DELAY_BOTTOM;
                else if (wdata[`CTRL_NORM_MIDDLE])
                    delay <= `DELAY_MIDDLE;
                else
                    delay <= `DELAY_TOP;
            end
            if (cmd_filter)
                filter_mode <= 1'b1;
            if (cmd_advance)
            begin
                delay <= delay + `WINDOW_STEP;
                target_restart <= 1'b1;
            end
            if (cmd_snap)
            begin
                filter_mode <= 1'b0;
                restart_flag <= 1'b0;
                delay <= `WINDOW_STEP;
            end
            if (cmd_start && !cmd_snap && !cmd_advance)
                target_restart <= restart_flag;
            if (wr_en && addr == `ADDR_DELAY)
                delay <= wdata[15:0];
            if (wr_en && addr == `ADDR_CONFIG)
                restart_flag <= wdata[`CONFIG_RESTART];
            if (wr_en && addr == `ADDR_QUAL)
            begin
                qual_en <= wdata[`QUAL_EN];
                qual_sel <= wdata[`QUAL_SEL_LSB+2:`QUAL_SEL_LSB];
                qual_val <= wdata[`QUAL_VAL_LSB+7:`QUAL_VAL_LSB];
            end
            if (wr_en && addr == `ADDR_TRACE_IDX)
                trace_idx <= wdata[PTR_W-1:0];
            if (go)
            begin
                wr_ptr <= {PTR_W{1'b0}};
                count <= {PTR_W{1'b0}};
                qual_seen <= 1'b0;
                state <= go_filter ? ST_FILTER : ST_SEARCH;
            end
            else
            begin
                if (store)
                begin
                    wr_ptr <= next_ptr;
                    if (count != DEPTH_W)
                        count <= count + 1'b1;
                end
                case (state)
                    ST_SEARCH:
                    begin
                        if (cyc && match)
                        begin
                            events[`IRQ_TRIG] <= 1'b1;
                            delay_left <= delay;
                            if (delay == 16'h0000)
                            begin
                                state <= ST_FROZEN;
                                events[`IRQ_FROZEN] <= 1'b1;
                            end
                            else
                                state <= ST_DELAY;
                        end
                    end
                    ST_DELAY:
                    begin
                        if (cyc)
                        begin
                            delay_left <= delay_left - 1'b1;
                            if (delay_left == 16'h0001)
                            begin
                                state <= ST_FROZEN;
                                events[`IRQ_FROZEN] <= 1'b1;
                            end
                        end
                    end
                    ST_FILTER:
                    begin
                        if (cyc && qual_en && qual_hit)
                            qual_seen <= 1'b1;
                        if (store_filter && count == LAST)
                        begin
                            state <= ST_FROZEN;
                            events[`IRQ_FROZEN] <= 1'b1;
                        end
                    end
                    ST_IDLE:
                        state <= ST_IDLE;
                    ST_FROZEN:
                        state <= ST_FROZEN;
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    wire [8*FIELDS-1:0] trace_word = trace_mem[trace_idx];
    wire irq_rd = rd_en && addr == `ADDR_IRQ_STAT;

    // A read clears the status, but an event in the same cycle still sets it.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
            rdata <= 32'h0;
        end
        else
        begin
            irq_stat <= (irq_rd ? 2'b00 : irq_stat) | events;
            if (wr_en && addr == `ADDR_IRQ_MASK)
                irq_mask <= wdata[1:0];
            rdata <= 32'h0;
            if (rd_en)
            begin
                case (addr)
                    `ADDR_DELAY: rdata <= {16'h0, delay};
                    `ADDR_STATUS: rdata <= {8'h0, wr_ptr, free_entries, 5'h0, state};
                    `ADDR_IRQ_STAT: rdata <= {30'h0, irq_stat};
                    `ADDR_IRQ_MASK: rdata <= {30'h0, irq_mask};
                    `ADDR_QUAL: rdata <= {16'h0, qual_val, 4'h0, qual_sel, qual_en};
                    `ADDR_CONFIG: rdata <= {31'h0, restart_flag};
                    `ADDR_TRACE_IDX: rdata <= {{(32-PTR_W){1'b0}}, trace_idx};
                    `ADDR_TRACE_LO: rdata <= trace_word[31:0];
                    `ADDR_TRACE_HI: rdata <= {16'h0, trace_word[47:32]};
                    default: rdata <= 32'h0;
                endcase
            end
        end
    end

    assign irq = |(irq_stat & irq_mask);
endmodule // bus_trigger_trace_capture
`default_nettype wire

//--- bus_trigger_trace_capture_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bus_trigger_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic irq,
    input wire logic target_restart
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic ctl = wr_en && addr == 8'h00;
    wire logic rdd = rd_en && addr == 8'h08;
    AST_NORM_BOTTOM: assert property (ctl && wdata[0] ##1 rdd |=> rdata == 32'h4)
        else $error("bottom delay wrong");
    AST_NORM_MIDDLE: assert property (ctl && wdata[1:0] == 2'h2 ##1 rdd |=> rdata == 32'h55)
        else $error("middle delay wrong");
    AST_NORM_TOP: assert property (ctl && wdata[2:0] == 3'h4 ##1 rdd |=> rdata == 32'hA5)
        else $error("top delay wrong");
    AST_ADVANCE_ADD: assert property (rdd ##1 ctl && wdata[5:0] == 6'h08 ##1 rdd |=>
        rdata == $past(rdata, 2) + 32'hAA) else $error("advance did not add the window step");
    AST_ADVANCE_RESTART: assert property (ctl && wdata[3] |=> target_restart)
        else $error("advance gave no restart");
    AST_SNAP_QUIET: assert property (ctl && wdata[5] && !wdata[3] && !wdata[6] |=> !target_restart)
        else $error("snapshot restarted the target");
    AST_RESTART_CAUSE: assert property (target_restart |-> $past(ctl))
        else $error("restart without a control write");
    AST_ARM_FREE: assert property (ctl && (wdata[5] || wdata[6]) ##1 rd_en && addr == 8'h0C |=>
        rdata[15:8] == 8'hAA && rdata[2:0] inside {3'h1, 3'h4}) else $error("arm left a wrong status");
    AST_READ_IDLE: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    AST_UNMAPPED: assert property (rd_en && (addr == 8'h00 || addr == 8'h04 || addr > 8'h28) |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_MASK_OFF: assert property (wr_en && addr == 8'h14 && wdata[1:0] == 2'h0 |=> !irq)
        else $error("masked interrupt raised");
endmodule // bus_trigger_chk
bind bus_trigger_trace_capture bus_trigger_chk u_chk (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .target_restart(target_restart));
`default_nettype wire

//--- bus_trigger_trace_capture_test.sv
`timescale 1ns/1ps
`default_nettype none
module bus_trigger_trace_capture_test;
    logic core_clk, rst, wr_en, rd_en, irq, target_restart, target_cycle_strobe;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, got;
    logic [47:0] target_bus, tv, trig;
    int errors, checks, restarts, r0, i;
    bus_trigger_trace_capture u_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .irq(irq), .target_bus(target_bus),
        .target_cycle_strobe(target_cycle_strobe), .target_restart(target_restart));
    target_bus_model u_tgt (.core_clk(core_clk), .target_bus(target_bus), .target_cycle_strobe(target_cycle_strobe));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (target_restart === 1'b1)
            restarts++;
    function automatic logic [31:0] stat(input logic [2:0] s, input logic [7:0] f, input logic [7:0] p);
        return {8'h0, p, f, 5'h0, s};
    endfunction
    function automatic logic [31:0] nd(input int p);
        return p == 0 ? 32'h4 : p == 1 ? 32'h55 : 32'hA5;
    endfunction
    function automatic logic [47:0] bv(input logic [23:0] low);
        return {24'($urandom), low};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        @(posedge core_clk);
        #1 got = rdata;
    endtask
    task automatic rc(input logic [7:0] a, input string n, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(n, e, got & m);
    endtask
    // Strobes drop before each bus cycle so that no register access repeats meanwhile.
    task automatic cyc(input logic [47:0] v);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge core_clk);
        u_tgt.bus_cycle(v, 2 + $urandom % 2);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // About 3100 cycles are needed; about thirteen times that leaves ample margin.
    initial
    begin
        #400000;
        errors++;
        give_verdict;
    end
    initial
    begin
        rst = 1'b1;
        {wr_en, rd_en, addr, wdata} = '0;
        {errors, checks, restarts} = '0;
        void'($urandom(19));
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rc(8'h08, "delay", 32'hFFFF, 32'h4);
        rc(8'h0C, "status", 32'hFFFFFF, stat(3'h0, 8'hAA, 8'h0));
        rc(8'h30, "unmapped", 32'hFFFFFFFF, 32'h0);
        wr(8'h14, 32'h0);
        rc(8'h1C, "restart flag", 32'hFFFFFFFF, 32'h0);
        for (i = 0; i < 3; i++)
        begin
            wr(8'h00, 32'h1 << i);
            rc(8'h08, "norm delay", 32'hFFFF, nd(i));
        end
        $display("test reset and normalize done");
        wr(8'h1C, 32'h1);
        wr(8'h14, 32'h3);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h00121200);
        r0 = restarts;
        wr(8'h00, 32'h40);
        for (i = 0; i < 9; i++)
        begin
            tv = bv({16'($urandom), i == 3 || i == 8 ? 8'h12 : 8'h13 + 8'(i)});
            cyc(tv);
            if (i == 3)
                trig = tv;
        end
        wr(8'h20, 32'h3);
        rc(8'h24, "trigger entry", 32'hFFFFFFFF, trig[31:0]);
        rc(8'h28, "trigger entry high", 32'hFFFFFFFF, {16'h0, trig[47:32]});
        rc(8'h0C, "frozen status", 32'hFFFFFF, stat(3'h3, 8'hA2, 8'h8));
        chk("irq", 32'h1, 32'(irq));
        rc(8'h10, "irq stat", 32'h3, 32'h3);
        chk("irq cleared", 32'h0, 32'(irq));
        chk("start restart", 32'(r0 + 1), 32'(restarts));
        $display("test trigger done");
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h80);
        wr(8'h04, 32'h00201001);
        wr(8'h04, 32'h00050502);
        wr(8'h00, 32'h40);
        cyc(bv(24'h051513));
        cyc(bv(24'h063013));
        rc(8'h0C, "invert search", 32'h7, 32'h1);
        cyc(bv(24'h053013));
        rc(8'h0C, "invert hit", 32'h7, 32'h2);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h00504002);
        wr(8'h00, 32'h180);
        wr(8'h04, 32'h00484802);
        wr(8'h00, 32'h40);
        cyc(bv(24'h480000));
        cyc(bv(24'h600000));
        rc(8'h0C, "or search", 32'h7, 32'h1);
        cyc(bv(24'h410000));
        rc(8'h0C, "or hit", 32'h7, 32'h2);
        $display("test invert done");
        wr(8'h00, 32'h10);
        wr(8'h04, 32'h00AAAA00);
        wr(8'h18, 32'h00007703);
        wr(8'h00, 32'h40);
        cyc(bv(24'h0000AA));
        cyc(bv(24'h0077AA));
        cyc(bv(24'h000001));
        cyc(bv(24'h0000AA));
        rc(8'h0C, "filter status", 32'hFFFFFF, stat(3'h4, 8'hA8, 8'h2));
        for (i = 0; i < 169; i++)
            cyc(bv({8'h0, 8'($urandom), 8'hAA}));
        rc(8'h0C, "filter full", 32'hFF07, stat(3'h3, 8'h0, 8'h0));
        wr(8'h14, 32'h0);
        $display("test filter done");
        wr(8'h1C, 32'h1);
        r0 = restarts;
        wr(8'h00, 32'h20);
        rc(8'h0C, "snap status", 32'hFF07, stat(3'h1, 8'hAA, 8'h0));
        rc(8'h1C, "snap flag", 32'hFFFFFFFF, 32'h0);
        rc(8'h08, "snap delay", 32'hFFFF, 32'hAA);
        for (i = 0; i < 170; i++)
            cyc(bv(24'($urandom)));
        rc(8'h0C, "snap running", 32'h7, 32'h2);
        cyc(bv(24'($urandom)));
        rc(8'h0C, "snap frozen", 32'h7, 32'h3);
        chk("snap restart", 32'(r0), 32'(restarts));
        wr(8'h08, 32'h10);
        rd(8'h08);
        wr(8'h00, 32'h08);
        rc(8'h08, "advance delay", 32'hFFFF, 32'hBA);
        chk("advance restart", 32'(r0 + 1), 32'(restarts));
        $display("test snapshot and advance done");
        give_verdict;
    end
endmodule // bus_trigger_trace_capture_test
`default_nettype wire

//--- target_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module target_bus_model (
    input wire logic core_clk,
    output logic [47:0] target_bus,
    output logic target_cycle_strobe
);
    initial
    begin
        target_bus = 48'h0;
        target_cycle_strobe = 1'b0;
    end
    // The pins go to the inverse once a cycle ends, so a stale value never looks valid.
    task automatic bus_cycle(input logic [47:0] v, input int hold);
        target_bus <= v;
        repeat (hold) @(posedge core_clk);
        target_cycle_strobe <= 1'b1;
        repeat (hold) @(posedge core_clk);
        target_cycle_strobe <= 1'b0;
        repeat (hold) @(posedge core_clk);
        target_bus <= ~v;
    endtask
endmodule // target_bus_model
`default_nettype wire
